// *** logic/qbp_ports.v ***
// Five-port latch, read path and pin driver logic
// Functional notes
// - Write strobe loads port latch
// - Separate latch read and pin read
// - Read-modify-write takes operand from latch
// - Bit write rewrites whole latch byte
// - Zero drives low, one releases pin
// - Latch one turns low driver off
// - Alternate output sets level on ports 1,3,4
// - Bus cycles drive ports 0,2 from bus
// - Port zero strong high only on bus
// - Port zero inputs float without pull-up
// - Ports one to four read high when released
// - Reset sets every latch bit to one
// - Latch updates at end, pins next cycle
// - Rising latch bit on ports one to four gives two-cycle strong pulse
// - High pin level enables weak keeper
// - Very weak pull-up when low driver off
// - Port one keeper and very weak pull-up off for analog
// - Port two strong pull-up during bus
`include "qbp_port_regs.vh"
module qbp_ports #(
   parameter WIDTH = 8,
   parameter P4_WIDTH = 2
) (
   input wire ref_clk,
   input wire sys_rst,
   input wire writeStrobe,
   input wire [2:0] portSel,
   input wire [2:0] opCode,
   input wire [2:0] bitSel,
   input wire bitValue,
   input wire [WIDTH-1:0] busData,
   input wire readLatch,
   input wire readPin,
   output reg [WIDTH-1:0] readData,
   output wire [WIDTH-1:0] rmwOperand,
   input wire extBusCycle,
   input wire [WIDTH-1:0] busAddrData0,
   input wire [WIDTH-1:0] busAddr2,
   input wire [WIDTH-1:0] altOut1,
   input wire [WIDTH-1:0] altOut3,
   input wire [P4_WIDTH-1:0] altOut4,
   input wire [WIDTH-1:0] analogSel1,
   input wire [WIDTH-1:0] pinIn0,
   input wire [WIDTH-1:0] pinIn1,
   input wire [WIDTH-1:0] pinIn2,
   input wire [WIDTH-1:0] pinIn3,
   input wire [P4_WIDTH-1:0] pinIn4,
   output reg [WIDTH-1:0] pinOut0,
   output reg [WIDTH-1:0] pinOe0,
   output reg [WIDTH-1:0] pinOut1,
   output reg [WIDTH-1:0] pinOe1,
   output reg [WIDTH-1:0] pinOut2,
   output reg [WIDTH-1:0] pinOe2,
   output reg [WIDTH-1:0] pinOut3,
   output reg [WIDTH-1:0] pinOe3,
   output reg [P4_WIDTH-1:0] pinOut4,
   output reg [P4_WIDTH-1:0] pinOe4,
   output wire [WIDTH-1:0] strongPullup1,
   output wire [WIDTH-1:0] strongPullup2,
   output wire [WIDTH-1:0] strongPullup3,
   output wire [P4_WIDTH-1:0] strongPullup4,
   output reg [WIDTH-1:0] strongBus0,
   output reg [4*WIDTH-1:0] weakKeeper,
   output reg [4*WIDTH-1:0] veryWeakPullup
);
   reg [WIDTH-1:0] portZeroLatch;
   reg [WIDTH-1:0] portOneLatch;
   reg [WIDTH-1:0] portTwoLatch;
   reg [WIDTH-1:0] portThreeLatch;
   reg [P4_WIDTH-1:0] portFourLatch;
   reg [WIDTH-1:0] next_latch;
   reg [WIDTH-1:0] selLatch;
   reg [WIDTH-1:0] selPin;
   wire [WIDTH-1:0] syncPin0;
   wire [WIDTH-1:0] syncPin1;
   wire [WIDTH-1:0] syncPin2;
   wire [WIDTH-1:0] syncPin3;
   wire [P4_WIDTH-1:0] syncPin4;
   wire [WIDTH-1:0] strong2Pulse;
   reg [WIDTH-1:0] drv0;
   reg [WIDTH-1:0] drv1;
   reg [WIDTH-1:0] drv2;
   reg [WIDTH-1:0] drv3;
   reg [P4_WIDTH-1:0] drv4;
   reg [WIDTH-1:0] strongBus2;
   reg busPhase2;

   // Apply the modify step to a latch operand
   function [WIDTH-1:0] modify;
      input [2:0] op;
      input [WIDTH-1:0] oldVal;
      input [WIDTH-1:0] arg;
      input [2:0] bitIdx;
      input bitVal;
      reg [WIDTH-1:0] tmp;
      begin
         tmp = oldVal;
         case (op)
            `QBP_OP_WRITE: tmp = arg;
            `QBP_OP_AND: tmp = oldVal & arg;
            `QBP_OP_OR: tmp = oldVal | arg;
            `QBP_OP_XOR: tmp = oldVal ^ arg;
            `QBP_OP_INC: tmp = oldVal + {{(WIDTH-1){1'b0}}, 1'b1};
            `QBP_OP_DEC: tmp = oldVal - {{(WIDTH-1){1'b0}}, 1'b1};
            `QBP_OP_BIT: tmp[bitIdx] = bitVal;
            `QBP_OP_CPL: tmp[bitIdx] = ~oldVal[bitIdx];
            default: tmp = oldVal;
         endcase
         modify = tmp;
      end
   endfunction

   // Pin levels resynchronised before use
   // A level changing near the edge never reaches the read mux half-settled
   qbp_sync #(.WIDTH(WIDTH)) uSync0 (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .asyncIn(pinIn0),
      .syncOut(syncPin0)
   );
   qbp_sync #(.WIDTH(WIDTH)) uSync1 (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .asyncIn(pinIn1),
      .syncOut(syncPin1)
   );
   qbp_sync #(.WIDTH(WIDTH)) uSync2 (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .asyncIn(pinIn2),
      .syncOut(syncPin2)
   );
   qbp_sync #(.WIDTH(WIDTH)) uSync3 (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .asyncIn(pinIn3),
      .syncOut(syncPin3)
   );
   qbp_sync #(.WIDTH(P4_WIDTH)) uSync4 (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .asyncIn(pinIn4),
      .syncOut(syncPin4)
   );

   // Strong pull-up pulses on ports one to four
   // Port two's pulse gives way to the bus drive while the bus owns the pins
   qbp_pulse #(.WIDTH(WIDTH)) uPulse1 (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .latchVal(portOneLatch),
      .strongPullupPulse(strongPullup1)
   );
   qbp_pulse #(.WIDTH(WIDTH)) uPulse2 (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .latchVal(portTwoLatch),
      .strongPullupPulse(strong2Pulse)
   );
   qbp_pulse #(.WIDTH(WIDTH)) uPulse3 (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .latchVal(portThreeLatch),
      .strongPullupPulse(strongPullup3)
   );
   qbp_pulse #(.WIDTH(P4_WIDTH)) uPulse4 (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .latchVal(portFourLatch),
      .strongPullupPulse(strongPullup4)
   );

   // Port two also drives strong high for bus ones; the registered copy
   // keeps the strong pull-up in step with the registered low driver,
   // so the two never fight for one cycle at a bus edge
   assign strongPullup2 = busPhase2 ? strongBus2 : strong2Pulse;

   // Select latch and pin of the addressed port
   always @* begin
      case (portSel)
         `QBP_PORT0: begin
            selLatch = portZeroLatch;
            selPin = syncPin0;
         end
         `QBP_PORT1: begin
            selLatch = portOneLatch;
            selPin = syncPin1;
         end
         `QBP_PORT2: begin
            selLatch = portTwoLatch;
            selPin = syncPin2;
         end
         `QBP_PORT3: begin
            selLatch = portThreeLatch;
            selPin = syncPin3;
         end
         `QBP_PORT4: begin
            selLatch = {{(WIDTH-P4_WIDTH){1'b0}}, portFourLatch};
            selPin = {{(WIDTH-P4_WIDTH){1'b0}}, syncPin4};
         end
         default: begin
            selLatch = {WIDTH{1'b0}};
            selPin = {WIDTH{1'b0}};
         end
      endcase
   end

   // Modify steps always use the latch, never the pins
   assign rmwOperand = selLatch;

   // Next latch value for the addressed port
   always @* begin
      next_latch = modify(opCode, selLatch, busData, bitSel, bitValue);
   end

   // Port latches: reset to ones, loaded at end of the write cycle
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         portZeroLatch <= `QBP_LATCH_RESET;
         portOneLatch <= `QBP_LATCH_RESET;
         portTwoLatch <= `QBP_LATCH_RESET;
         portThreeLatch <= `QBP_LATCH_RESET;
         portFourLatch <= {P4_WIDTH{1'b1}};
      end else if (writeStrobe) begin
         case (portSel)
            `QBP_PORT0: portZeroLatch <= next_latch;
            `QBP_PORT1: portOneLatch <= next_latch;
            `QBP_PORT2: portTwoLatch <= next_latch;
            `QBP_PORT3: portThreeLatch <= next_latch;
            `QBP_PORT4: portFourLatch <= next_latch[P4_WIDTH-1:0];
            default: portZeroLatch <= portZeroLatch;
         endcase
      end
   end

   // Read data registered from latch or pin path
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         readData <= {WIDTH{1'b0}};
      end else if (readLatch) begin
         readData <= selLatch;
      end else if (readPin) begin
         readData <= selPin;
      end
   end

   // Driver source levels: bus or latch, alternate output gated by latch
   always @* begin
      drv0 = extBusCycle ? busAddrData0 : portZeroLatch;
      drv1 = portOneLatch & altOut1;
      drv2 = extBusCycle ? busAddr2 : portTwoLatch;
      drv3 = portThreeLatch & altOut3;
      drv4 = portFourLatch & altOut4;
   end

   // Port zero buffer: open drain, strong high only while the bus owns it
   // Pin buffers register one cycle after the latch changes
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pinOut0 <= {WIDTH{1'b0}};
         pinOe0 <= {WIDTH{1'b1}};
         strongBus0 <= {WIDTH{1'b0}};
      end else begin
         pinOut0 <= {WIDTH{1'b0}};
         pinOe0 <= drv0;
         strongBus0 <= extBusCycle ? busAddrData0 : {WIDTH{1'b0}};
      end
   end

   // Port one buffer
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pinOut1 <= {WIDTH{1'b0}};
         pinOe1 <= {WIDTH{1'b1}};
      end else begin
         pinOut1 <= {WIDTH{1'b0}};
         pinOe1 <= drv1;
      end
   end

   // Port two buffer with its bus strong drive held in the same cycle
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pinOut2 <= {WIDTH{1'b0}};
         pinOe2 <= {WIDTH{1'b1}};
         strongBus2 <= {WIDTH{1'b0}};
         busPhase2 <= 1'b0;
      end else begin
         pinOut2 <= {WIDTH{1'b0}};
         pinOe2 <= drv2;
         strongBus2 <= extBusCycle ? busAddr2 : {WIDTH{1'b0}};
         busPhase2 <= extBusCycle;
      end
   end

   // Port three buffer
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pinOut3 <= {WIDTH{1'b0}};
         pinOe3 <= {WIDTH{1'b1}};
      end else begin
         pinOut3 <= {WIDTH{1'b0}};
         pinOe3 <= drv3;
      end
   end

   // Port four buffer
   // Only the low bits exist on this narrow port
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pinOut4 <= {P4_WIDTH{1'b0}};
         pinOe4 <= {P4_WIDTH{1'b1}};
      end else begin
         pinOut4 <= {P4_WIDTH{1'b0}};
         pinOe4 <= drv4;
      end
   end

   // Weak keepers follow the synchronised pin level (port zero has none)
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         weakKeeper <= {4*WIDTH{1'b0}};
      end else begin
         weakKeeper <= {{(WIDTH-P4_WIDTH){1'b0}}, syncPin4, syncPin3, syncPin2,
            syncPin1 & ~analogSel1};
      end
   end

   // Very weak pull-ups on ports one to four wherever the low driver is off and the pin is not analog
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         veryWeakPullup <= {4*WIDTH{1'b1}};
      end else begin
         veryWeakPullup <= {{(WIDTH-P4_WIDTH){1'b0}}, drv4, drv3, drv2,
            drv1 & ~analogSel1};
      end
   end
endmodule // qbp_ports

// *** logic/qbp_port_regs.vh ***
// Constants for the quasi-bidirectional port latch block
`ifndef QBP_PORT_REGS_VH
`define QBP_PORT_REGS_VH
`define QBP_LATCH_RESET 8'hff
`define QBP_PULSE_CYCLES 2
`define QBP_PULSE_NS 200
`define QBP_CLK_NS 100
`define QBP_PORT0 3'h0
`define QBP_PORT1 3'h1
`define QBP_PORT2 3'h2
`define QBP_PORT3 3'h3
`define QBP_PORT4 3'h4
`define QBP_OP_WRITE 3'h0
`define QBP_OP_AND 3'h1
`define QBP_OP_OR 3'h2
`define QBP_OP_XOR 3'h3
`define QBP_OP_INC 3'h4
`define QBP_OP_DEC 3'h5
`define QBP_OP_BIT 3'h6
`define QBP_OP_CPL 3'h7
`endif

// *** logic/qbp_sync.v ***
// Two-flop synchroniser for pin levels
module qbp_sync #(
   parameter WIDTH = 8
) (
   input wire ref_clk,
   input wire sys_rst,
   input wire [WIDTH-1:0] asyncIn,
   output reg [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] stageOne;

   // First stage feeds only the second
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stageOne <= {WIDTH{1'b1}};
         syncOut <= {WIDTH{1'b1}};
      end else begin
         stageOne <= asyncIn;
         syncOut <= stageOne;
      end
   end
endmodule // qbp_sync

// *** logic/qbp_pulse.v ***
// Strong pull-up pulse generator for one port
`include "qbp_port_regs.vh"
module qbp_pulse #(
   parameter WIDTH = 8,
   parameter CLK_NS = `QBP_CLK_NS,
   parameter PULSE_NS = `QBP_PULSE_NS
) (
   input wire ref_clk,
   input wire sys_rst,
   input wire [WIDTH-1:0] latchVal,
   output reg [WIDTH-1:0] strongPullupPulse
);
   localparam integer CYC_RAW = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam integer CYC = (CYC_RAW < 1) ? 1 : CYC_RAW;
   reg [WIDTH-1:0] prevLatch;
   reg [2*WIDTH-1:0] count;
   integer i;

   // Per-bit counter started by a zero-to-one latch edge
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prevLatch <= {WIDTH{1'b1}};
         count <= {2*WIDTH{1'b0}};
         strongPullupPulse <= {WIDTH{1'b0}};
      end else begin
         prevLatch <= latchVal;
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (latchVal[i] && !prevLatch[i]) begin
               count[2*i +: 2] <= CYC[1:0] - 2'h1;
               strongPullupPulse[i] <= 1'b1;
            end else if (count[2*i +: 2] != 2'h0) begin
               count[2*i +: 2] <= count[2*i +: 2] - 2'h1;
               strongPullupPulse[i] <= 1'b1;
            end else begin
               strongPullupPulse[i] <= 1'b0;
            end
         end
      end
   end
endmodule // qbp_pulse

// *** dv/qbp_ports_monitor.sv ***
// Concurrent checks on the port latch block outputs
module qbp_ports_monitor (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic writeStrobe,
   input wire logic [2:0] portSel,
   input wire logic [2:0] opCode,
   input wire logic [7:0] busData,
   input wire logic readLatch,
   input wire logic extBusCycle,
   input wire logic [7:0] busAddrData0,
   input wire logic [7:0] busAddr2,
   input wire logic [7:0] readData,
   input wire logic [7:0] rmwOperand,
   input wire logic [7:0] pinOut0,
   input wire logic [7:0] pinOut1,
   input wire logic [7:0] pinOe0,
   input wire logic [7:0] pinOe2,
   input wire logic [7:0] strongPullup1,
   input wire logic [7:0] strongPullup3,
   input wire logic [7:0] strongBus0
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // Strong pull-up pulse lasts two clocks
   pulse_one_a: assert property ($rose(strongPullup1[0]) |=> strongPullup1[0] ##1 !strongPullup1[0])
      else $error("port one pulse length wrong");
   pulse_three_a: assert property ($rose(strongPullup3[0]) |=> strongPullup3[0] ##1 !strongPullup3[0])
      else $error("port three pulse length wrong");
   // Port zero strong drive, bus hand-over on ports zero and two, low pin data
   strong_off_a: assert property (!$past(extBusCycle) |-> strongBus0 == 8'h00)
      else $error("port zero strong drive outside bus");
   bus_zero_a: assert property ($past(extBusCycle) |-> pinOe0 == $past(busAddrData0))
      else $error("port zero not fed from bus");
   bus_two_a: assert property ($past(extBusCycle) |-> pinOe2 == $past(busAddr2))
      else $error("port two not fed from bus");
   drive_low_a: assert property ((pinOut0 | pinOut1) == 8'h00)
      else $error("pin data not low");
   // Latch write and read paths
   latch_write_a: assert property (writeStrobe && opCode == 3'h0 && portSel < 3'h4
      |=> !$stable(portSel) || rmwOperand == $past(busData))
      else $error("latch write lost");
   latch_read_a: assert property (readLatch && !writeStrobe && portSel < 3'h5
      |=> readData == $past(rmwOperand))
      else $error("latch read wrong");
   cover property ($rose(strongPullup3[0]));
   cover property (extBusCycle ##1 !extBusCycle);
   cover property (readLatch && portSel == 3'h4);
endmodule // qbp_ports_monitor

bind qbp_ports qbp_ports_monitor u_mon (.ref_clk, .sys_rst, .writeStrobe, .portSel, .opCode, .busData,
   .readLatch, .extBusCycle, .busAddrData0, .busAddr2, .readData, .rmwOperand, .pinOut0, .pinOut1,
   .pinOe0, .pinOe2, .strongPullup1, .strongPullup3, .strongBus0);

// *** dv/qbp_pin_model.sv ***
// Pin model: external drivers, pull-ups and floating lines
module qbp_pin_model #(
   parameter W = 34,
   parameter [W-1:0] PULL = '1
) (
   input wire logic ref_clk,
   input wire logic [W-1:0] oe,
   input wire logic [W-1:0] drv,
   input wire logic [W-1:0] ext,
   output logic [W-1:0] pin
);
   logic flip = 1'b0;
   // Undriven lines without pull-up wander each clock
   always @(posedge ref_clk) begin
      flip <= ~flip;
   end
   // Low driver wins, then external source, then pull-up
   assign pin = oe & ((drv & ext) | (~drv & (PULL | {W{flip}})));
endmodule // qbp_pin_model

// *** dv/quasi_bidir_port_latches_tb.sv ***
// Testbench for the five-port latch block
`include "qbp_port_regs.vh"
module quasi_bidir_port_latches_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 0, sys_rst = 1, writeStrobe = 0, bitValue = 0, readLatch = 0, readPin = 0, extBusCycle = 0;
   logic [2:0] portSel = 0, opCode = 0, bitSel = 0;
   logic [7:0] busData = 0, busAddrData0 = 0, busAddr2 = 0, altOut1 = 0, altOut3 = 0, analogSel1 = 0, v;
   logic [1:0] altOut4 = 0;
   logic [33:0] drv = '1, ext = '1, pins;
   wire [7:0] readData, rmwOperand, pinOe0, pinOe1, pinOe2, pinOe3;
   wire [1:0] pinOe4;
   wire [7:0] sp2, sb0;
   wire [31:0] wk, vwp;
   logic [7:0] lat [5];
   int miscompares = 0, checks_done = 0;
   qbp_ports u_dut (.ref_clk, .sys_rst, .writeStrobe, .portSel, .opCode, .bitSel, .bitValue, .busData,
      .readLatch, .readPin, .readData, .rmwOperand, .extBusCycle, .busAddrData0, .busAddr2, .altOut1,
      .altOut3, .altOut4, .analogSel1, .pinIn0(pins[7:0]), .pinIn1(pins[15:8]), .pinIn2(pins[23:16]),
      .pinIn3(pins[31:24]), .pinIn4(pins[33:32]), .pinOut0(), .pinOe0, .pinOut1(), .pinOe1, .pinOut2(),
      .pinOe2, .pinOut3(), .pinOe3, .pinOut4(), .pinOe4, .strongPullup1(), .strongPullup2(sp2),
      .strongPullup3(), .strongPullup4(), .strongBus0(sb0), .weakKeeper(wk), .veryWeakPullup(vwp));
   qbp_pin_model #(.W(34), .PULL({2'b11, 24'hffffff, 8'h00})) u_pins (.ref_clk,
      .oe({pinOe4, pinOe3, pinOe2, pinOe1, pinOe0}), .drv, .ext, .pin(pins));
   // Clock and watchdog
   always #50 ref_clk = ~ref_clk;
   initial begin
      #(100 * 20000);
      miscompares++;
      end_of_test;
   end
   // Expected latch after an operation
   function automatic logic [7:0] f_rmw(input [2:0] o, input [7:0] a, d, input [2:0] b, input bv);
      logic [7:0] r;
      r = a;
      case (o)
         0: r = d;
         1: r = a & d;
         2: r = a | d;
         3: r = a ^ d;
         4: r = a + 8'h01;
         5: r = a - 8'h01;
         6: r[b] = bv;
         default: r[b] = ~a[b];
      endcase
      return r;
   endfunction
   // Expected and seen low-driver release per port
   function automatic logic [7:0] f_oe(input [2:0] p);
      case (p)
         1: return lat[1] & altOut1;
         3: return lat[3] & altOut3;
         4: return lat[4] & {6'h00, altOut4};
         default: return lat[p];
      endcase
   endfunction
   function automatic logic [7:0] g_oe(input [2:0] p);
      case (p)
         0: return pinOe0;
         1: return pinOe1;
         2: return pinOe2;
         3: return pinOe3;
         default: return {6'h00, pinOe4};
      endcase
   endfunction
   task chk(input [7:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task end_of_test;
      if (miscompares == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One write or read-modify-write, then latch, read-back and driver checks
   task do_op(input [2:0] p, o, input [7:0] d, input [2:0] b, input bv);
      @(negedge ref_clk);
      {portSel, opCode, busData, bitSel, bitValue, writeStrobe} = {p, o, d, b, bv, 1'b1};
      @(negedge ref_clk);
      writeStrobe = 0;
      if (p < 5) lat[p] = f_rmw(o, lat[p], d, b, bv) & (p == 4 ? 8'h03 : 8'hff);
      if (p < 5) chk(rmwOperand, lat[p]);
      rd(p, 0, v);
      chk(v, p < 5 ? lat[p] : 8'h00);
      if (p < 5) chk(g_oe(p), f_oe(p));
   endtask
   task rd(input [2:0] p, input pin, output [7:0] r);
      @(negedge ref_clk);
      {portSel, readLatch, readPin} = {p, !pin, pin};
      @(negedge ref_clk);
      {readLatch, readPin} = 2'b00;
      r = readData;
   endtask
   // Main sequence
   initial begin
      lat = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h03};
      void'($urandom(32'ha7e4));
      repeat (10) @(negedge ref_clk);
      sys_rst = 0;
      for (int p = 0; p < 5; p++) begin
         rd(p, 0, v);
         chk(v, lat[p]);
      end
      for (int i = 0; i < 16; i++) do_op(i % 5, i % 8, 8'h5a, i % 8, i[0]);
      for (int i = 0; i < 60; i++) begin
         {altOut1, altOut3, altOut4, analogSel1} = {$urandom, $urandom};
         {drv, ext} = {$urandom, $urandom, $urandom};
         do_op($urandom % 6, $urandom % 8, $urandom, $urandom % 8, $urandom % 2);
         repeat (3) @(negedge ref_clk);
         rd(3, 1, v);
         chk(v, f_oe(3) & ((drv[31:24] & ext[31:24]) | ~drv[31:24]));
         chk(wk[23:16], f_oe(3) & ((drv[31:24] & ext[31:24]) | ~drv[31:24]));
         chk(vwp[23:16], f_oe(3));
         chk(vwp[7:0], f_oe(1) & ~analogSel1);
         if (i % 10 == 0) begin
            extBusCycle = 1;
            repeat (6) @(negedge ref_clk) {busAddrData0, busAddr2} = 16'($urandom);
            @(negedge ref_clk);
            chk(sb0, busAddrData0);
            chk(sp2, busAddr2);
            extBusCycle = 0;
            repeat (3) @(negedge ref_clk);
            chk(pinOe0, lat[0]);
            chk(sb0, 8'h00);
         end
      end
      end_of_test;
   end
endmodule // quasi_bidir_port_latches_tb
